// File: src/gfr_pkg.sv
package gfr_pkg;
   // ========================================
   // Command word layout
   localparam int GFR_RW_BIT = 31;
   localparam int GFR_CODE_MSB = 30;
   localparam int GFR_CODE_LSB = 27;
   localparam logic [3:0] GFR_CODE_FLAGS = 4'hF;
   localparam logic GFR_RW_READ = 1'h0;
   // ========================================
   // Flag positions
   localparam int GFR_BIT_SURGE = 3;
   localparam int GFR_BIT_ALIGN = 2;
   localparam int GFR_BIT_GATE_OFF = 1;
   localparam int GFR_BIT_RESET_FALL = 0;
   // ========================================
   // Values after reset
   localparam logic GFR_RST_SURGE = 1'h0;
   localparam logic GFR_RST_ALIGN = 1'h0;
   localparam logic GFR_RST_GATE_OFF = 1'h1;
   localparam logic GFR_RST_RESET_FALL = 1'h1;
   localparam logic [2:0] GFR_SYNC_INIT = 3'h7;
   localparam logic [2:0] GFR_SYNC_INIT_LOW = 3'h0;
endpackage

// File: src/gfr_sync.sv
module gfr_sync
   import gfr_pkg::*;
#(
   parameter logic [2:0] INIT = 3'h0
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic pin,
   output logic level,
   output logic fall,
   output logic rise
);
   logic [2:0] sync_reg;
   logic level_reg;

   always_ff @(posedge core_clk)
   begin
      if (rst)
         sync_reg <= INIT;
      else
         sync_reg <= {sync_reg[1:0], pin};
   end

   // Accept a change once stages two and three agree
   always_ff @(posedge core_clk)
   begin
      if (rst)
         level_reg <= INIT[2];
      else if (sync_reg[1] == sync_reg[2])
         level_reg <= sync_reg[2];
   end

   assign level = level_reg;
   assign fall = level_reg & ~sync_reg[2] & ~sync_reg[1];
   assign rise = ~level_reg & sync_reg[2] & sync_reg[1];
endmodule

// File: src/gfr_flag_readout.sv
// Overview of operation
// - Command with bit 31 low and code 1111 requests the flag word.
// - Supply surge flag sets on overvoltage, holds until a read with no overvoltage standing, resets 0.
// - Alignment pulse flag sets on phase sync, holds until read, resets 0.
// - Gate-off latch resets to 1, forced 1 while enable is low.
// - Read with enable high clears gate-off latch; enable low keeps 1.
// - Reset-fall latch resets to 1; a read clears it unless a fall arrives in the same cycle.
// - Falling edge on the active-low reset input sets reset-fall latch.
module gfr_flag_readout
   import gfr_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic [31:0] cmd_word,
   output logic rsp_valid,
   output logic [31:0] rsp_word,
   input wire logic surge_evt,
   input wire logic align_pin,
   input wire logic enable_pin,
   input wire logic reset_n_pin
);
   // ========================================
   // Input conditioning
   logic en_level;
   logic align_rise;
   logic rstn_fall;
   logic surge_sync_level;
   logic surge_rise;

   gfr_sync #(.INIT(GFR_SYNC_INIT)) u_en_sync
   (
      .core_clk(core_clk),
      .rst(rst),
      .pin(enable_pin),
      .level(en_level),
      .fall(),
      .rise()
   );

   gfr_sync #(.INIT(GFR_SYNC_INIT_LOW)) u_align_sync
   (
      .core_clk(core_clk),
      .rst(rst),
      .pin(align_pin),
      .level(),
      .fall(),
      .rise(align_rise)
   );

   gfr_sync #(.INIT(GFR_SYNC_INIT)) u_rstn_sync
   (
      .core_clk(core_clk),
      .rst(rst),
      .pin(reset_n_pin),
      .level(),
      .fall(rstn_fall),
      .rise()
   );

   gfr_sync #(.INIT(GFR_SYNC_INIT_LOW)) u_surge_sync
   (
      .core_clk(core_clk),
      .rst(rst),
      .pin(surge_evt),
      .level(surge_sync_level),
      .fall(),
      .rise(surge_rise)
   );

   // ========================================
   // Command decode
   logic rd_hit;
   assign rd_hit = cmd_valid && (cmd_word[GFR_RW_BIT] == GFR_RW_READ)
      && (cmd_word[GFR_CODE_MSB:GFR_CODE_LSB] == GFR_CODE_FLAGS);

   // ========================================
   // Flags
   logic surge_reg;
   logic align_reg;
   logic gate_off_reg;
   logic reset_fall_reg;

   always_ff @(posedge core_clk)
   begin
      if (rst)
         surge_reg <= GFR_RST_SURGE;
      else if (surge_rise || surge_sync_level)
         surge_reg <= 1'h1;
      else if (rd_hit)
         surge_reg <= 1'h0;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         align_reg <= GFR_RST_ALIGN;
      else if (align_rise)
         align_reg <= 1'h1;
      else if (rd_hit)
         align_reg <= 1'h0;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         gate_off_reg <= GFR_RST_GATE_OFF;
      else if (!en_level)
         gate_off_reg <= 1'h1;
      else if (rd_hit)
         gate_off_reg <= 1'h0;
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         reset_fall_reg <= GFR_RST_RESET_FALL;
      else if (rstn_fall)
         reset_fall_reg <= 1'h1;
      else if (rd_hit)
         reset_fall_reg <= 1'h0;
   end

   // ========================================
   // Reply, built from pre-clear flag values
   logic rsp_valid_reg;
   logic [31:0] rsp_word_reg;

   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         rsp_valid_reg <= 1'h0;
         rsp_word_reg <= 32'h0000_0000;
      end
      else
      begin
         rsp_valid_reg <= rd_hit;
         if (rd_hit)
         begin
            rsp_word_reg <= 32'h0000_0000;
            rsp_word_reg[GFR_RW_BIT] <= GFR_RW_READ;
            rsp_word_reg[GFR_CODE_MSB:GFR_CODE_LSB] <= GFR_CODE_FLAGS;
            rsp_word_reg[GFR_BIT_SURGE] <= surge_reg;
            rsp_word_reg[GFR_BIT_ALIGN] <= align_reg;
            rsp_word_reg[GFR_BIT_GATE_OFF] <= gate_off_reg;
            rsp_word_reg[GFR_BIT_RESET_FALL] <= reset_fall_reg;
         end
      end
   end

   assign rsp_valid = rsp_valid_reg;
   assign rsp_word = rsp_word_reg;

   // ========================================
   // Checks
   AST_RSP_FRAME: assert property (@(posedge core_clk) disable iff (rst)
      rd_hit |=> rsp_valid && rsp_word[31:27] == 5'h0F && rsp_word[26:4] == 23'h0)
      else $error("reply framing wrong");
   AST_RSP_ONLY_ON_CMD: assert property (@(posedge core_clk) disable iff (rst)
      rsp_valid |-> $past(rd_hit))
      else $error("reply without read command");
   AST_SURGE_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      surge_reg && !rd_hit |=> surge_reg)
      else $error("surge flag lost before read");
   AST_ALIGN_SET: assert property (@(posedge core_clk) disable iff (rst)
      align_rise |=> align_reg)
      else $error("alignment flag not set");
   AST_GATE_FORCED: assert property (@(posedge core_clk) disable iff (rst)
      !en_level |=> gate_off_reg)
      else $error("gate-off latch not forced");
   AST_GATE_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
      rd_hit && en_level |=> !gate_off_reg)
      else $error("gate-off latch not cleared");
   AST_RF_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
      rd_hit && !rstn_fall |=> !reset_fall_reg)
      else $error("reset-fall latch not cleared");
   AST_RF_SET: assert property (@(posedge core_clk) disable iff (rst)
      rstn_fall |=> reset_fall_reg)
      else $error("reset-fall latch not set");
   AST_RSP_FLAGS: assert property (@(posedge core_clk) disable iff (rst)
      rd_hit |=> rsp_word[3:0] == $past({surge_reg, align_reg, gate_off_reg, reset_fall_reg}))
      else $error("reply flags differ from latched flags");

   // Set, hold, clear, reset-value and refusal checks
   AST_SURGE_SET: assert property (@(posedge core_clk) disable iff (rst)
      surge_sync_level |=> surge_reg)
      else $error("surge flag not set while overvoltage stands");
   AST_SURGE_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
      rd_hit && !surge_rise && !surge_sync_level |=> !surge_reg)
      else $error("surge flag not cleared by read");
   AST_ALIGN_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      align_reg && !rd_hit |=> align_reg)
      else $error("alignment flag lost before read");
   AST_ALIGN_CLEAR: assert property (@(posedge core_clk) disable iff (rst)
      rd_hit && !align_rise |=> !align_reg)
      else $error("alignment flag not cleared by read");
   AST_GATE_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      gate_off_reg && !rd_hit |=> gate_off_reg)
      else $error("gate-off latch dropped without read");
   AST_RF_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      reset_fall_reg && !rd_hit |=> reset_fall_reg)
      else $error("reset-fall latch dropped without read");
   AST_RESET_STATE: assert property (@(posedge core_clk)
      $fell(rst) |-> !surge_reg && !align_reg && gate_off_reg && reset_fall_reg)
      else $error("flags not at reset values");
   AST_RSP_STANDS: assert property (@(posedge core_clk) disable iff (rst)
      !rd_hit |=> $stable(rsp_word))
      else $error("reply word changed without read");
   AST_WRITE_NO_REPLY: assert property (@(posedge core_clk) disable iff (rst)
      cmd_valid && cmd_word[GFR_RW_BIT] |=> !rsp_valid)
      else $error("reply to a write command");
   AST_OTHER_CODE_NO_REPLY: assert property (@(posedge core_clk) disable iff (rst)
      cmd_valid && cmd_word[GFR_CODE_MSB:GFR_CODE_LSB] != GFR_CODE_FLAGS |=> !rsp_valid)
      else $error("reply to another message code");
endmodule

// File: test/gfr_host.sv
module gfr_host
   import gfr_pkg::*;
(
   input wire logic core_clk,
   output logic cmd_valid,
   output logic [31:0] cmd_word,
   output logic align_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      cmd_valid = 1'h0;
      cmd_word = 32'h0;
      align_pin = 1'h0;
   end
   task automatic send(input logic [31:0] w);
      @(negedge core_clk);
      cmd_valid = 1'h1;
      cmd_word = w;
      @(negedge core_clk);
      cmd_valid = 1'h0;
      cmd_word = ~w;
   endtask
   task automatic pulse();
      @(negedge core_clk);
      align_pin = 1'h1;
      repeat (3) @(negedge core_clk);
      align_pin = 1'h0;
   endtask
endmodule

// File: test/tb_gfr_flag_readout.sv
module tb_gfr_flag_readout
   import gfr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk, rst, cmd_valid, rsp_valid, surge_evt, align_pin, enable_pin, reset_n_pin;
   logic [31:0] cmd_word, rsp_word, v, last_rsp;
   int err_count, num_checks, cycles, s, a, g, r;
   logic [31:0] exp_q[$];
   initial
   begin
      core_clk = 1'h0;
      forever #4 core_clk = ~core_clk;
   end
   gfr_flag_readout i_dut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_word(cmd_word), .rsp_valid(rsp_valid), .rsp_word(rsp_word), .surge_evt(surge_evt),
      .align_pin(align_pin), .enable_pin(enable_pin), .reset_n_pin(reset_n_pin));
   gfr_host i_host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
      .align_pin(align_pin));
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want)
      begin
         err_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Reference read: reply before clearing
   task automatic rd();
      exp_q.push_back({1'h0, GFR_CODE_FLAGS, 23'h0, s[0], a[0], g[0], r[0]});
      i_host.send({GFR_RW_READ, GFR_CODE_FLAGS, 27'($urandom)});
      s = 0;
      a = 0;
      r = 0;
      if (enable_pin)
         g = 0;
   endtask
   always @(negedge core_clk)
   begin
      cycles++;
      if (cycles > 4000)
      begin
         err_count++;
         test_done();
      end
      if (rsp_valid === 1'h1)
      begin
         last_rsp = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hFFFFFFFF;
         check(rsp_word, last_rsp);
      end
      else if (rst === 1'h0)
         check(rsp_word, last_rsp);
   end
   initial
   begin
      rst = 1'h1;
      surge_evt = 1'h0;
      enable_pin = 1'h1;
      reset_n_pin = 1'h1;
      s = 0;
      a = 0;
      g = 1;
      r = 1;
      last_rsp = 32'h0;
      void'($urandom(32'h0411));
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'h0;
      rd();
      for (int i = 0; i < 16; i++)
      begin
         v = $urandom;
         @(negedge core_clk);
         surge_evt = v[0];
         enable_pin = v[1];
         reset_n_pin = ~v[2];
         if (v[3])
            i_host.pulse();
         repeat (2) @(negedge core_clk);
         surge_evt = 1'h0;
         reset_n_pin = 1'h1;
         repeat (6) @(negedge core_clk);
         s |= v[0];
         a |= v[3];
         r |= v[2];
         if (!v[1])
            g = 1;
         // Writes and other codes refused
         i_host.send({1'h1, GFR_CODE_FLAGS, 27'($urandom)});
         i_host.send({1'h0, (v[7:4] == 4'hF) ? 4'h0 : v[7:4], 27'h0});
         rd();
         rd();
      end
      repeat (4) @(negedge core_clk);
      check(32'(exp_q.size()), 32'h0);
      test_done();
   end
endmodule
